// File: pkg/tmcb_defs.vh
`ifndef TMCB_DEFS_VH
`define TMCB_DEFS_VH

// ==============================================
// Register byte offsets
`define TMCB_ADDR_ENC_PIN   8'h7C
`define TMCB_ADDR_OT_DIV    8'h7D
`define TMCB_ADDR_TEST_A    8'h7E
`define TMCB_ADDR_TEST_B    8'h7F

// ==============================================
// Reset values
`define TMCB_RST_ENC_PIN    8'h01
`define TMCB_RST_OT_DIV     8'h00
`define TMCB_RST_TEST       8'h00
`define TMCB_RDATA_IDLE     8'h00

// ==============================================
// encoding_and_pin_config fields
`define TMCB_B_SIGNED       0
`define TMCB_B_OFS_RANGE    1
`define TMCB_B_AUX_DIR      2
`define TMCB_B_AUX_POL      3
`define TMCB_B_ID_GROUP     4
`define TMCB_B_R1_OT        5
`define TMCB_B_LOC_OT       6
`define TMCB_B_R2_OT        7

// ==============================================
// overtemp_and_divider_config fields
`define TMCB_F_PINFN_HI     1
`define TMCB_F_PINFN_LO     0
`define TMCB_B_OT_DIS       2
`define TMCB_B_FAN_TGT      3
`define TMCB_B_BYP_2V5      4
`define TMCB_B_BYP_CORE     5
`define TMCB_B_BYP_5V       6
`define TMCB_B_BYP_12V      7

// ==============================================
// Shared pin function codes
`define TMCB_FN_TACH        2'h0
`define TMCB_FN_OVERTEMP    2'h1
`define TMCB_FN_ALERT       2'h2
`define TMCB_FN_GPIO        2'h3

// ==============================================
// Temperature coding
`define TMCB_OFS64_BIAS     9'h040
`define TMCB_OFF_LIM_OFS64  8'h00
`define TMCB_OFF_LIM_SIGNED 8'h80
`define TMCB_CHANNELS       3
`define TMCB_ID_PINS        5

`endif

// File: hw/tmcb_config_bank.v
// How it works
// - Encoding bit picks signed or offset-64 temperatures
// - Offset range bit picks half or one degree
// - Direction bit: aux pin input 0, output 1
// - Polarity bit: aux output low 0, high 1
// - Group bit routes five pins: voltage-ID or GPIO
// - Channel enable lets its limit drive overtemp pin
// - Limit at -64 or -128 disables channel
// - Lock set makes both config registers read-only
// - Shared pin: tach, overtemp, alert, or GPIO
// - Disable bit suppresses overtemp drive on both pins, not fan response
// - Overtemp drives fans full or to maximum registers
// - Bypass bits rescale four voltage input channels
// - Reset values 0x01 and 0x00
`timescale 1ns/1ps
`include "tmcb_defs.vh"

module tmcb_config_bank (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       reset,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  // Lock from another configuration register
  input  wire       config_lock,
  // Stored temperature readings
  input  wire [7:0] remote1_temp,
  input  wire [7:0] local_temp,
  input  wire [7:0] remote2_temp,
  // Stored overtemp limits
  input  wire [7:0] remote1_limit,
  input  wire [7:0] local_limit,
  input  wire [7:0] remote2_limit,
  // Configuration outputs
  output reg        signed_encoding_select,
  output reg        offset_range_wide,
  output reg        aux_pin_direction,
  output reg        aux_pin_polarity,
  output reg        id_pin_group_select,
  output reg        remote1_overtemp_enable,
  output reg        local_overtemp_enable,
  output reg        remote2_overtemp_enable,
  output reg  [1:0] shared_pin_function,
  output reg        overtemp_output_disable,
  output reg        overtemp_fan_target_select,
  output reg        bypass_divider_2v5,
  output reg        bypass_divider_core,
  output reg        bypass_divider_5v,
  output reg        bypass_divider_12v,
  // Per-channel limit state
  output reg  [2:0] channel_over_limit,
  // Overtemp pin, open drain, active low
  input  wire       overtemp_pin_in,
  output reg        overtemp_pin_out,
  output reg        overtemp_pin_oe_n,
  output reg        overtemp_timer_sense,
  // Shared multi-purpose pin
  input  wire       shared_pin_in,
  output reg        shared_pin_out,
  output reg        shared_pin_oe_n,
  input  wire       smbus_alert_request,
  input  wire       aux_out_request,
  output reg        aux_general_pin,
  output reg        fan4_tach_input,
  // Five shared voltage-ID / GPIO pins
  input  wire [4:0] id_pins_in,
  output reg  [4:0] voltage_id_inputs,
  output reg  [4:0] id_gpio_inputs,
  // Fan response
  output reg        fan_full_speed,
  output reg        fan_max_register
);

  // ==============================================
  // Register storage
  reg  [7:0] encoding_and_pin_config;
  reg  [7:0] overtemp_and_divider_config;
  wire [7:0] factory_test_a;
  wire [7:0] factory_test_b;
  wire       write_open;
  wire       hit_enc;
  wire       hit_ot;

  assign factory_test_a = `TMCB_RST_TEST;
  assign factory_test_b = `TMCB_RST_TEST;

  assign write_open = reg_write & ~config_lock;
  assign hit_enc    = (reg_addr == `TMCB_ADDR_ENC_PIN);
  assign hit_ot     = (reg_addr == `TMCB_ADDR_OT_DIV);

  always @(posedge ref_clk) begin
    if (reset) begin
      encoding_and_pin_config     <= `TMCB_RST_ENC_PIN;
      overtemp_and_divider_config <= `TMCB_RST_OT_DIV;
    end else begin
      if (write_open && hit_enc) begin
        encoding_and_pin_config <= reg_wdata;
      end
      if (write_open && hit_ot) begin
        overtemp_and_divider_config <= reg_wdata;
      end
    end
  end

  // ==============================================
  // Read path, data in the cycle after the strobe
  reg [7:0] next_rdata;

  always @* begin
    next_rdata = `TMCB_RDATA_IDLE;
    if (reg_read) begin
      case (reg_addr)
        `TMCB_ADDR_ENC_PIN: next_rdata = encoding_and_pin_config;
        `TMCB_ADDR_OT_DIV:  next_rdata = overtemp_and_divider_config;
        `TMCB_ADDR_TEST_A:  next_rdata = factory_test_a;
        `TMCB_ADDR_TEST_B:  next_rdata = factory_test_b;
        default:            next_rdata = `TMCB_RDATA_IDLE;
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= `TMCB_RDATA_IDLE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ==============================================
  // Field decode
  wire       enc_signed;
  wire       pin_fn_gpio;
  wire       pin_fn_tach;
  wire [1:0] pin_fn;
  wire [2:0] chan_enable;
  localparam [7:0] enc_pin_reset = `TMCB_RST_ENC_PIN;

  assign enc_signed = encoding_and_pin_config[`TMCB_B_SIGNED];
  assign pin_fn = overtemp_and_divider_config[`TMCB_F_PINFN_HI:
                                              `TMCB_F_PINFN_LO];
  assign pin_fn_tach  = (pin_fn == `TMCB_FN_TACH);
  assign pin_fn_gpio  = (pin_fn == `TMCB_FN_GPIO);
  assign chan_enable = {encoding_and_pin_config[`TMCB_B_R2_OT],
                        encoding_and_pin_config[`TMCB_B_LOC_OT],
                        encoding_and_pin_config[`TMCB_B_R1_OT]};

  always @(posedge ref_clk) begin
    if (reset) begin
      signed_encoding_select     <= enc_pin_reset[`TMCB_B_SIGNED];
      offset_range_wide          <= 1'b0;
      aux_pin_direction          <= 1'b0;
      aux_pin_polarity           <= 1'b0;
      id_pin_group_select        <= 1'b0;
      remote1_overtemp_enable    <= 1'b0;
      local_overtemp_enable      <= 1'b0;
      remote2_overtemp_enable    <= 1'b0;
      shared_pin_function        <= `TMCB_FN_TACH;
      overtemp_output_disable    <= 1'b0;
      overtemp_fan_target_select <= 1'b0;
      bypass_divider_2v5         <= 1'b0;
      bypass_divider_core        <= 1'b0;
      bypass_divider_5v          <= 1'b0;
      bypass_divider_12v         <= 1'b0;
    end else begin
      signed_encoding_select  <= enc_signed;
      offset_range_wide       <=
        encoding_and_pin_config[`TMCB_B_OFS_RANGE];
      aux_pin_direction       <=
        encoding_and_pin_config[`TMCB_B_AUX_DIR];
      aux_pin_polarity        <=
        encoding_and_pin_config[`TMCB_B_AUX_POL];
      id_pin_group_select     <=
        encoding_and_pin_config[`TMCB_B_ID_GROUP];
      remote1_overtemp_enable <= chan_enable[0];
      local_overtemp_enable   <= chan_enable[1];
      remote2_overtemp_enable <= chan_enable[2];
      shared_pin_function     <= pin_fn;
      overtemp_output_disable <=
        overtemp_and_divider_config[`TMCB_B_OT_DIS];
      overtemp_fan_target_select <=
        overtemp_and_divider_config[`TMCB_B_FAN_TGT];
      bypass_divider_2v5  <=
        overtemp_and_divider_config[`TMCB_B_BYP_2V5];
      bypass_divider_core <=
        overtemp_and_divider_config[`TMCB_B_BYP_CORE];
      bypass_divider_5v   <=
        overtemp_and_divider_config[`TMCB_B_BYP_5V];
      bypass_divider_12v  <=
        overtemp_and_divider_config[`TMCB_B_BYP_12V];
    end
  end

  // ==============================================
  // Temperature interpretation per channel
  // Stored codes are never rewritten; each compare reads
  // them through the encoding currently selected.
  function [8:0] tmcb_to_signed;
    input [7:0] code;
    input       is_signed;
    begin
      if (is_signed) begin
        tmcb_to_signed = {code[7], code};
      end else begin
        tmcb_to_signed = {1'b0, code} - `TMCB_OFS64_BIAS;
      end
    end
  endfunction

  wire [23:0] temp_bus;
  wire [23:0] limit_bus;
  wire [2:0]  chan_exceed;
  wire [2:0]  next_over;

  assign temp_bus  = {remote2_temp, local_temp, remote1_temp};
  assign limit_bus = {remote2_limit, local_limit, remote1_limit};

  genvar ch;
  generate
    for (ch = 0; ch < `TMCB_CHANNELS; ch = ch + 1) begin : g_chan
      wire [7:0] t_code;
      wire [7:0] l_code;
      wire [8:0] t_val;
      wire [8:0] l_val;
      wire       lim_off;
      assign t_code = temp_bus[ch*8 +: 8];
      assign l_code = limit_bus[ch*8 +: 8];
      assign t_val = tmcb_to_signed(t_code, enc_signed);
      assign l_val = tmcb_to_signed(l_code, enc_signed);
      assign lim_off = enc_signed ?
        (l_code == `TMCB_OFF_LIM_SIGNED) :
        (l_code == `TMCB_OFF_LIM_OFS64);
      assign chan_exceed[ch] = ($signed(t_val) > $signed(l_val));
      assign next_over[ch] = chan_exceed[ch] & ~lim_off &
                             chan_enable[ch];
    end
  endgenerate

  // ==============================================
  // Overtemp drive and fan response
  wire any_over;
  wire ot_drive;

  assign any_over = |next_over;
  assign ot_drive = any_over &
    ~overtemp_and_divider_config[`TMCB_B_OT_DIS];

  always @(posedge ref_clk) begin
    if (reset) begin
      channel_over_limit   <= 3'h0;
      overtemp_pin_out     <= 1'b0;
      overtemp_pin_oe_n    <= 1'b1;
      overtemp_timer_sense <= 1'b0;
      fan_full_speed       <= 1'b0;
      fan_max_register     <= 1'b0;
    end else begin
      channel_over_limit <= next_over;
      overtemp_pin_out   <= 1'b0;
      // Pin is pulled low only while a qualified limit is exceeded
      overtemp_pin_oe_n  <= ~ot_drive;
      overtemp_timer_sense <= ~overtemp_pin_in;
      fan_full_speed   <= any_over &
        ~overtemp_and_divider_config[`TMCB_B_FAN_TGT];
      fan_max_register <= any_over &
        overtemp_and_divider_config[`TMCB_B_FAN_TGT];
    end
  end

  // ==============================================
  // Shared pin function
  wire aux_dir_out;
  wire aux_level;

  assign aux_dir_out = encoding_and_pin_config[`TMCB_B_AUX_DIR];
  assign aux_level = encoding_and_pin_config[`TMCB_B_AUX_POL] ?
                     aux_out_request : ~aux_out_request;

  reg next_sh_out;
  reg next_sh_oe_n;

  always @* begin
    next_sh_out  = 1'b1;
    next_sh_oe_n = 1'b1;
    case (pin_fn)
      `TMCB_FN_OVERTEMP: begin
        next_sh_out  = 1'b0;
        next_sh_oe_n = ~ot_drive;
      end
      `TMCB_FN_ALERT: begin
        next_sh_out  = 1'b0;
        next_sh_oe_n = ~smbus_alert_request;
      end
      `TMCB_FN_GPIO: begin
        next_sh_out  = aux_level;
        next_sh_oe_n = ~aux_dir_out;
      end
      default: begin
        next_sh_out  = 1'b1;
        next_sh_oe_n = 1'b1;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      shared_pin_out  <= 1'b1;
      shared_pin_oe_n <= 1'b1;
      aux_general_pin <= 1'b0;
      fan4_tach_input <= 1'b0;
    end else begin
      shared_pin_out  <= next_sh_out;
      shared_pin_oe_n <= next_sh_oe_n;
      aux_general_pin <= pin_fn_gpio & ~aux_dir_out &
                         shared_pin_in;
      fan4_tach_input <= pin_fn_tach & shared_pin_in;
    end
  end

  // ==============================================
  // Voltage-ID / GPIO pin group routing
  wire id_sel;

  assign id_sel = encoding_and_pin_config[`TMCB_B_ID_GROUP];

  genvar pn;
  generate
    for (pn = 0; pn < `TMCB_ID_PINS; pn = pn + 1) begin : g_idpin
      always @(posedge ref_clk) begin
        if (reset) begin
          voltage_id_inputs[pn] <= 1'b0;
          id_gpio_inputs[pn]    <= 1'b0;
        end else begin
          voltage_id_inputs[pn] <= ~id_sel & id_pins_in[pn];
          id_gpio_inputs[pn]    <= id_sel & id_pins_in[pn];
        end
      end
    end
  endgenerate

endmodule

// File: bench/tmcb_props.sv
`timescale 1ns/1ps
module tmcb_props (
  // Clock, reset and register port
  input wire       ref_clk,
  input wire       reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_write,
  input wire       reg_read,
  input wire [7:0] reg_rdata,
  input wire       config_lock,
  // Limit and derived state
  input wire [7:0] local_limit,
  input wire       signed_encoding_select,
  input wire       local_overtemp_enable,
  input wire [1:0] shared_pin_function,
  input wire       overtemp_output_disable,
  input wire       overtemp_fan_target_select,
  input wire [2:0] channel_over_limit,
  input wire       overtemp_pin_oe_n,
  input wire       shared_pin_oe_n,
  input wire       smbus_alert_request,
  input wire       fan_full_speed,
  input wire       fan_max_register
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ==================================
  // Sequences
  sequence s_enc_wr;
    reg_write && reg_addr == 8'h7C;
  endsequence
  sequence s_locked_wr;
    s_enc_wr ##0 config_lock ##1 !(reg_write && !config_lock);
  endsequence
  // ==================================
  // Properties
  property p_enc_wr;
    s_enc_wr ##0 !config_lock |-> ##2
      {7'h00, signed_encoding_select} == ($past(reg_wdata, 2) & 8'h01);
  endproperty
  property p_lock;
    s_locked_wr |=> $stable(signed_encoding_select);
  endproperty
  property p_test_rd;
    reg_read && reg_addr[7:1] == 7'h3F |=> reg_rdata == 8'h00;
  endproperty
  property p_oe;
    overtemp_pin_oe_n ==
      !(|channel_over_limit && !overtemp_output_disable);
  endproperty
  property p_fan;
    fan_full_speed == (|channel_over_limit && !overtemp_fan_target_select)
      && fan_max_register ==
      (|channel_over_limit && overtemp_fan_target_select);
  endproperty
  property p_alert;
    shared_pin_function == 2'h2 |-> shared_pin_oe_n ==
      !$past(smbus_alert_request);
  endproperty
  property p_tach;
    shared_pin_function == 2'h0 |-> shared_pin_oe_n;
  endproperty
  property p_chan_en;
    channel_over_limit[1] |-> local_overtemp_enable;
  endproperty
  property p_chan_off;
    channel_over_limit[1] |-> $past(local_limit) !=
      (signed_encoding_select ? 8'h80 : 8'h00);
  endproperty
  a_enc_wr: assert property (p_enc_wr)
    else $error("encoding bit did not follow write");
  a_lock: assert property (p_lock)
    else $error("locked write changed register");
  a_test_rd: assert property (p_test_rd)
    else $error("test register read not zero");
  a_oe: assert property (p_oe)
    else $error("overtemp pin drive wrong");
  a_fan: assert property (p_fan)
    else $error("fan response wrong");
  a_alert: assert property (p_alert)
    else $error("alert function drive wrong");
  a_tach: assert property (p_tach)
    else $error("tach function drives pin");
  a_chan_en: assert property (p_chan_en)
    else $error("disabled channel over limit");
  a_chan_off: assert property (p_chan_off)
    else $error("disable code limit tripped");
endmodule

// File: bench/tb_thermal_monitor_config_bank.sv
`timescale 1ns/1ps
module tb_thermal_monitor_config_bank;
  logic       ref_clk = 1'h0, reset = 1'h1, reg_write = 1'h0;
  logic       reg_read = 1'h0, config_lock = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       smbus_alert_request = 1'h1, aux_out_request = 1'h0;
  logic [7:0] remote1_temp = 8'h00, local_temp = 8'h00;
  logic [7:0] remote2_temp = 8'h00, local_limit = 8'h00;
  logic [7:0] remote1_limit = 8'h7F, remote2_limit = 8'h7F;
  logic [4:0] id_pins_in = 5'h15, voltage_id_inputs, id_gpio_inputs;
  logic       signed_encoding_select, offset_range_wide;
  logic       aux_pin_direction, aux_pin_polarity, id_pin_group_select;
  logic       remote1_overtemp_enable, local_overtemp_enable;
  logic       remote2_overtemp_enable, overtemp_output_disable;
  logic [1:0] shared_pin_function;
  logic       overtemp_fan_target_select, bypass_divider_2v5;
  logic       bypass_divider_core, bypass_divider_5v, bypass_divider_12v;
  logic       overtemp_pin_out, overtemp_pin_oe_n, overtemp_timer_sense;
  logic       shared_pin_out, shared_pin_oe_n, aux_general_pin;
  logic       fan4_tach_input, fan_full_speed, fan_max_register;
  logic [2:0] channel_over_limit;
  int         n_errors = 0, samples_checked = 0;
  // Open-drain pins with pull-ups
  wire        overtemp_pin_in = overtemp_pin_oe_n | overtemp_pin_out;
  wire        shared_pin_in = shared_pin_oe_n | shared_pin_out;

  tmcb_config_bank DUT (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .config_lock(config_lock),
    .remote1_temp(remote1_temp), .local_temp(local_temp),
    .remote2_temp(remote2_temp), .remote1_limit(remote1_limit),
    .local_limit(local_limit), .remote2_limit(remote2_limit),
    .signed_encoding_select(signed_encoding_select),
    .offset_range_wide(offset_range_wide),
    .aux_pin_direction(aux_pin_direction),
    .aux_pin_polarity(aux_pin_polarity),
    .id_pin_group_select(id_pin_group_select),
    .remote1_overtemp_enable(remote1_overtemp_enable),
    .local_overtemp_enable(local_overtemp_enable),
    .remote2_overtemp_enable(remote2_overtemp_enable),
    .shared_pin_function(shared_pin_function),
    .overtemp_output_disable(overtemp_output_disable),
    .overtemp_fan_target_select(overtemp_fan_target_select),
    .bypass_divider_2v5(bypass_divider_2v5),
    .bypass_divider_core(bypass_divider_core),
    .bypass_divider_5v(bypass_divider_5v),
    .bypass_divider_12v(bypass_divider_12v),
    .channel_over_limit(channel_over_limit),
    .overtemp_pin_in(overtemp_pin_in),
    .overtemp_pin_out(overtemp_pin_out),
    .overtemp_pin_oe_n(overtemp_pin_oe_n),
    .overtemp_timer_sense(overtemp_timer_sense),
    .shared_pin_in(shared_pin_in), .shared_pin_out(shared_pin_out),
    .shared_pin_oe_n(shared_pin_oe_n),
    .smbus_alert_request(smbus_alert_request),
    .aux_out_request(aux_out_request),
    .aux_general_pin(aux_general_pin),
    .fan4_tach_input(fan4_tach_input), .id_pins_in(id_pins_in),
    .voltage_id_inputs(voltage_id_inputs),
    .id_gpio_inputs(id_gpio_inputs),
    .fan_full_speed(fan_full_speed),
    .fan_max_register(fan_max_register)
  );

  always #12.5 ref_clk = ~ref_clk;
  // ==================================
  // Shared tasks
  task automatic chk(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Field copies of the encoding and pin register, bit 7 down to 0
  function automatic logic [7:0] cfg_out;
    return {remote2_overtemp_enable, local_overtemp_enable,
      remote1_overtemp_enable, id_pin_group_select, aux_pin_polarity,
      aux_pin_direction, offset_range_wide, signed_encoding_select};
  endfunction
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge ref_clk);
    reg_write <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge ref_clk);
    reg_read <= 1'h0;
    #1 chk("reg_rdata", reg_rdata, exp);
  endtask
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic lim(input logic [7:0] l, input logic [2:0] exp);
    @(posedge ref_clk);
    local_limit <= l;
    settle;
    chk("channel_over_limit", {5'h00, channel_over_limit}, {5'h00, exp});
  endtask
  // ==================================
  // Scenarios
  task automatic t_defaults;
    rd(8'h7C, 8'h01);
    rd(8'h7D, 8'h00);
    rd(8'h7E, 8'h00);
    rd(8'h7F, 8'h00);
    rd(8'h10, 8'h00);
    chk("config", cfg_out(), 8'h01);
    $display("test defaults done");
  endtask
  task automatic t_lock;
    wr(8'h7D, 8'hFF);
    wr(8'h7C, 8'hFF);
    rd(8'h7D, 8'hFF);
    wr(8'h10, 8'h55);
    rd(8'h7E, 8'h00);
    settle;
    chk("bypass", {4'h0, bypass_divider_12v, bypass_divider_5v,
      bypass_divider_core, bypass_divider_2v5}, 8'h0F);
    chk("config", cfg_out(), 8'hFF);
    @(posedge ref_clk);
    config_lock <= 1'h1;
    wr(8'h7C, 8'hA4);
    wr(8'h7D, 8'h00);
    rd(8'h7C, 8'hFF);
    rd(8'h7D, 8'hFF);
    @(posedge ref_clk);
    config_lock <= 1'h0;
    wr(8'h7D, 8'h00);
    $display("test lock done");
  endtask
  task automatic t_over;
    wr(8'h7C, 8'h41);
    @(posedge ref_clk);
    local_temp <= 8'h90;
    lim(8'h10, 3'h0);
    wr(8'h7C, 8'h40);
    lim(8'h10, 3'h2);
    chk("oe_n", {7'h00, overtemp_pin_oe_n}, 8'h00);
    chk("ot_out", {7'h00, overtemp_pin_out}, 8'h00);
    chk("sense", {7'h00, overtemp_timer_sense}, 8'h01);
    chk("fan", {6'h00, fan_full_speed, fan_max_register}, 8'h02);
    lim(8'h00, 3'h0);
    wr(8'h7C, 8'h41);
    lim(8'h80, 3'h0);
    lim(8'h81, 3'h2);
    wr(8'h7D, 8'h08);
    settle;
    chk("fan", {6'h00, fan_full_speed, fan_max_register}, 8'h01);
    wr(8'h7D, 8'h04);
    settle;
    chk("oe_n", {7'h00, overtemp_pin_oe_n}, 8'h01);
    wr(8'h7C, 8'h01);
    lim(8'h81, 3'h0);
    $display("test overtemp done");
  endtask
  task automatic t_pins;
    logic [3:0] sp;
    sp = 4'h3;
    wr(8'h7C, 8'h05);
    for (int f = 0; f < 4; f++) begin
      wr(8'h7D, f[7:0]);
      settle;
      chk("shared_oe_n", {7'h00, shared_pin_oe_n}, {7'h00, sp[f]});
      chk("tach", {7'h00, fan4_tach_input}, {7'h00, f == 0});
    end
    chk("shared_out", {7'h00, shared_pin_out}, 8'h01);
    chk("vid", {3'h0, voltage_id_inputs}, 8'h15);
    wr(8'h7C, 8'h0D);
    settle;
    chk("shared_out", {7'h00, shared_pin_out}, 8'h00);
    wr(8'h7C, 8'h11);
    settle;
    chk("gpio", {3'h0, id_gpio_inputs}, 8'h15);
    chk("vid", {3'h0, voltage_id_inputs}, 8'h00);
    chk("aux", {7'h00, aux_general_pin}, 8'h01);
    $display("test pins done");
  endtask
  // ==================================
  // Sequence and verdict
  task automatic print_verdict;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'h0;
    t_defaults;
    t_lock;
    t_over;
    t_pins;
    print_verdict;
  end
  initial begin
    #100000;
    n_errors++;
    print_verdict;
  end
endmodule

bind tmcb_config_bank tmcb_props u_props (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .config_lock(config_lock),
  .local_limit(local_limit),
  .signed_encoding_select(signed_encoding_select),
  .local_overtemp_enable(local_overtemp_enable),
  .shared_pin_function(shared_pin_function),
  .overtemp_output_disable(overtemp_output_disable),
  .overtemp_fan_target_select(overtemp_fan_target_select),
  .channel_over_limit(channel_over_limit),
  .overtemp_pin_oe_n(overtemp_pin_oe_n),
  .shared_pin_oe_n(shared_pin_oe_n),
  .smbus_alert_request(smbus_alert_request),
  .fan_full_speed(fan_full_speed),
  .fan_max_register(fan_max_register)
);
